/* dv/interpolated_position_sync_test.sv */
// Purpose: Self-checking bench for the interpolating setpoint block.
// Assumes: Cycle time 8 us, so a bus cycle ends exactly at t = 1.0.
// Notes:   Ramps are equally spaced, so every method must land on the newest demand.
`timescale 1ns/1ps
module interpolated_position_sync_test;
  import ips_pkg::*;
  logic                    clk = 1'b0;
  logic                    rstn = 1'b0;
  logic                    setpoint_valid;
  logic signed [POS_W-1:0] setpoint_pos;
  logic                    sync_telegram_in;
  logic [2:0]              interp_sel = SEL_LIN_A;
  logic                    sync_sel = SYNC_PLL;
  logic                    cycle_time_wr = 1'b0;
  logic [CYC_W-1:0]        cycle_time_us = 16'h0008;
  logic [POS_W-1:0]        modulo_range = '0;
  logic [7:0]              sync_period_us = 8'h00;
  logic signed [POS_W-1:0] position_cmd;
  logic                    position_cmd_valid;
  logic                    sync_method_active;
  logic                    method_fault;
  logic [CYC_W-1:0]        sync_interval_ticks;
  logic signed [CYC_W-1:0] pll_phase_err;
  logic signed [POS_W-1:0] exp_pos;
  logic signed [POS_W-1:0] prev;
  logic [2:0]              sels [4] = '{SEL_LIN_A, SEL_LIN_B, SEL_QUAD, SEL_CUBIC};
  int                      err_total = 0;
  int                      checks = 0;
  int                      seed = 40952;
  int                      cyc_cnt = 0;

  always #5 clk = ~clk;

  interpolated_position_sync u_interpolated_position_sync (
    .clk(clk), .rstn(rstn), .setpoint_valid(setpoint_valid), .setpoint_pos(setpoint_pos),
    .sync_telegram_in(sync_telegram_in), .interpolation_method_select(interp_sel),
    .sync_method_select(sync_sel), .cycle_time_wr(cycle_time_wr),
    .cycle_time_us(cycle_time_us), .modulo_range(modulo_range), .position_cmd(position_cmd),
    .position_cmd_valid(position_cmd_valid), .sync_method_active(sync_method_active),
    .method_fault(method_fault), .sync_interval_ticks(sync_interval_ticks),
    .pll_phase_err(pll_phase_err));

  ips_master_model u_ips_master_model (
    .clk(clk), .sync_period_us(sync_period_us), .setpoint_valid(setpoint_valid),
    .setpoint_pos(setpoint_pos), .sync_telegram_in(sync_telegram_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check

  // Leaves the caller at a falling edge, where outputs are settled
  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      int g;
      g = 0;
      do begin
        @(negedge clk);
        g++;
      end while (position_cmd_valid !== 1'b1 && g < 150);
      check(position_cmd_valid === 1'b1, "tick missing");
    end
  endtask : ticks

  // Reconfigure only with no demand in flight
  task automatic setup(input logic sm, input logic [CYC_W-1:0] ct);
    @(posedge clk);
    sync_sel <= sm;
    cycle_time_us <= ct;
    cycle_time_wr <= 1'b1;
    @(posedge clk);
    cycle_time_wr <= 1'b0;
    repeat (30) @(posedge clk);
    @(negedge clk);
  endtask : setup

  // Four equally spaced demands fill even the cubic history
  task automatic ramp(input logic [2:0] sel, input logic [POS_W-1:0] mr, input int cyc,
                      output logic signed [POS_W-1:0] last);
    logic signed [POS_W-1:0] s;
    logic signed [POS_W-1:0] d;
    s = ($random(seed) & 32'h0001FFFF) + 2000;
    d = $random(seed) % 500;
    @(posedge clk);
    interp_sel <= sel;
    for (int k = 0; k < 4; k++) begin
      u_ips_master_model.send(s + k * d);
      // Range switches only once the new method is in force
      if (k == 0) begin
        modulo_range <= mr;
      end
      ticks(cyc);
    end
    last = s + 3 * d;
  endtask : ramp

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      err_total++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(position_cmd === '0 && sync_method_active === SYNC_PLL, "reset state");
    setup(SYNC_PLL, 16'h0008);
    @(posedge clk);
    sync_sel <= SYNC_TSTAMP;
    repeat (40) @(negedge clk);
    check(sync_method_active === SYNC_PLL, "method taken without write");
    setup(SYNC_TSTAMP, 16'h0008);
    check(sync_method_active === SYNC_TSTAMP, "method ignored on write");
    setup(SYNC_PLL, 16'h0008);
    foreach (sels[i]) begin
      ramp(sels[i], (i > 1) ? 32'h000003E8 : '0, 8, exp_pos);
      ticks(2);
      check(position_cmd === exp_pos, "ramp end");
      check(method_fault === 1'b0, "fault in phase lock");
    end
    // Step 990 -> 10 must take the short way across the wrap
    // Old ramp demands lie outside the range, so the range is applied once 990 has landed
    @(posedge clk);
    modulo_range <= '0;
    interp_sel <= SEL_LIN_A;
    u_ips_master_model.send(32'sh000003DE);
    ticks(10);
    @(posedge clk);
    modulo_range <= 32'h000003E8;
    prev = 32'sh000003DE;
    u_ips_master_model.send(32'sh0000000A);
    for (int k = 0; k < 10; k++) begin
      ticks(1);
      check(position_cmd >= 0 && position_cmd < 1000, "wrap range");
      check((position_cmd - prev + 1000) % 1000 <= 5, "wrap path");
      prev = position_cmd;
    end
    check(position_cmd === 32'sh0000000A, "wrap end");
    @(posedge clk);
    modulo_range <= '0;
    sync_period_us <= 8'h04;
    setup(SYNC_TSTAMP, 16'h0008);
    ticks(20);
    check(sync_interval_ticks >= 3 && sync_interval_ticks <= 5, "interval");
    ramp(SEL_LIN_B, '0, 4, exp_pos);
    check(method_fault === 1'b1, "linear under interval");
    ticks(2);
    check(position_cmd === exp_pos, "scaled ramp end");
    @(posedge clk);
    sync_period_us <= 8'h08;
    setup(SYNC_PLL, 16'h0008);
    ticks(40);
    check(pll_phase_err >= -16'sd1 && pll_phase_err <= 16'sd1, "phase error");
    check(sync_interval_ticks >= 7 && sync_interval_ticks <= 9, "pll interval");
    summarize();
  end
endmodule : interpolated_position_sync_test

/* dv/ips_master_model.sv */
// Purpose: Behavioural network master: cyclic position demands and sync pin.
// Assumes: Driven from the bench on clk; one demand per call, never back to back.
// Notes:   Sync pulses are strictly periodic, so jitter is zero.
`timescale 1ns/1ps
module ips_master_model
  import ips_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [7:0]          sync_period_us,
  output logic                     setpoint_valid,
  output logic signed [POS_W-1:0]  setpoint_pos,
  output logic                     sync_telegram_in
);
  int unsigned cnt;

  initial begin
    cnt = 0;
    setpoint_valid = 1'b0;
    setpoint_pos = '0;
    sync_telegram_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin idles low between pulses; period 0 stops the telegrams
  always @(posedge clk) begin
    if (sync_period_us == 8'h00) begin
      cnt <= 0;
      sync_telegram_in <= 1'b0;
    end else begin
      cnt <= (cnt + 1 >= sync_period_us * TICK_CYC) ? 0 : cnt + 1;
      sync_telegram_in <= (cnt < 5);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data is scrambled after the pulse so a late sample cannot pass
  task automatic send(input logic signed [POS_W-1:0] pos);
    @(posedge clk);
    setpoint_valid <= 1'b1;
    setpoint_pos <= pos;
    @(posedge clk);
    setpoint_valid <= 1'b0;
    setpoint_pos <= ~pos;
  endtask : send
endmodule : ips_master_model

/* rtl/interpolated_position_sync.sv */
// Purpose: Interpolates cyclic position demands between bus cycles and aligns to the master.
// Assumes: setpoint_valid is a one-cycle pulse from bus logic on clk; sync comes from a pin.
// Notes:   Output is refreshed once per 1 us control tick.
`timescale 1ns/1ps
module interpolated_position_sync
  import ips_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    setpoint_valid,
  input  wire logic signed [POS_W-1:0] setpoint_pos,
  input  wire logic                    sync_telegram_in,
  input  wire logic [2:0]              interpolation_method_select,
  input  wire logic                    sync_method_select,
  input  wire logic                    cycle_time_wr,
  input  wire logic [CYC_W-1:0]        cycle_time_us,
  input  wire logic [POS_W-1:0]        modulo_range,
  output logic signed [POS_W-1:0]      position_cmd,
  output logic                         position_cmd_valid,
  output logic                         sync_method_active,
  output logic                         method_fault,
  output logic [CYC_W-1:0]             sync_interval_ticks,
  output logic signed [CYC_W-1:0]      pll_phase_err
);
  typedef struct packed {
    logic                    s1;
    logic                    s2;
    logic                    s3;
    logic                    sync_f;
    logic [TICK_W-1:0]       div_cnt;
    logic                    mode;
    logic [CYC_W-1:0]        cycle_ticks;
    logic [CYC_W-1:0]        tick_cnt;
    logic [CYC_W-1:0]        cyc_cnt;
    logic [CYC_W-1:0]        interval;
    logic signed [CYC_W-1:0] phase_err;
    logic [FRAC_W:0]         frac;
    logic [FRAC_W:0]         step;
    logic signed [POS_W-1:0] p0;
    logic signed [POS_W-1:0] p1;
    logic signed [POS_W-1:0] p2;
    logic signed [POS_W-1:0] p3;
    logic [1:0]              fill;
    logic signed [CW-1:0]    cf3;
    logic signed [CW-1:0]    cf2;
    logic signed [CW-1:0]    cf1;
    method_t                 method;
    logic signed [POS_W-1:0] pos;
    logic                    pos_vld;
    logic                    fault;
    logic                    div_start;
  } st_t;

  st_t st_q;
  st_t st_d;

  logic            div_busy;
  logic            div_done;
  logic [FRAC_W:0] div_quot;

  // Fixed point product of a coefficient and the Q16 time fraction
  function automatic logic signed [CW-1:0] mulq(input logic signed [CW-1:0] x,
                                                input logic [FRAC_W:0]      t);
    logic signed [CW+FRAC_W+1:0] p;
    p = x * $signed({1'b0, t});
    return CW'(p >>> FRAC_W);
  endfunction : mulq

  function automatic logic signed [CW-1:0] ext(input logic signed [POS_W-1:0] v);
    return CW'(v);
  endfunction : ext

  recip_div #(.N_W(CYC_W), .Q_W(FRAC_W + 1)) u_step_div (
    .clk     (clk),
    .rstn    (rstn),
    .start   (st_q.div_start),
    .divisor (st_q.mode == SYNC_TSTAMP ? st_q.interval : st_q.cycle_ticks),
    .busy    (div_busy),
    .done    (div_done),
    .quot    (div_quot)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic                 tick;
    logic                 sync_edge;
    logic signed [CW-1:0] n0, n1, n2, n3, dl, md, y;
    logic                 lin_sel;
    logic [FRAC_W+1:0]    fsum;
    tick = 1'b0; sync_edge = 1'b0; lin_sel = 1'b0;
    fsum = '0;
    n0 = '0; n1 = '0; n2 = '0; n3 = '0; dl = '0; md = '0; y = '0;
    st_d           = st_q;
    st_d.pos_vld   = 1'b0;
    st_d.div_start = 1'b0;
    md             = CW'($signed({1'b0, modulo_range}));

    // Pin sync: a level counts once the second and third stages agree
    st_d.s1 = sync_telegram_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.sync_f = st_q.s3;
    end
    sync_edge = st_d.sync_f & ~st_q.sync_f;

    if (st_q.div_cnt == TICK_W'(TICK_CYC - 1)) begin
      st_d.div_cnt = '0;
      tick         = 1'b1;
    end else begin
      st_d.div_cnt = st_q.div_cnt + 1'b1;
    end

    // Method switch is held back until the cycle time is written again
    if (cycle_time_wr) begin
      st_d.mode        = sync_method_select;
      st_d.cycle_ticks = (cycle_time_us == '0) ? CYC_W'(1) : cycle_time_us;
      st_d.div_start   = 1'b1;
    end

    if (tick) begin
      if (st_q.tick_cnt != '1) begin
        st_d.tick_cnt = st_q.tick_cnt + 1'b1;
      end
      // Internal frame; free-running in interval mode, so beats are possible
      if (st_q.cyc_cnt >= st_q.cycle_ticks - 1'b1) begin
        st_d.cyc_cnt = '0;
      end else begin
        st_d.cyc_cnt = st_q.cyc_cnt + 1'b1;
      end
      // One spare bit, so a full step from a one-tick cycle cannot wrap to zero
      fsum      = {1'b0, st_q.frac} + {1'b0, st_q.step};
      st_d.frac = (fsum > {1'b0, FRAC_ONE}) ? FRAC_ONE : fsum[FRAC_W:0];
      // Horner evaluation at the elapsed fraction of the bus cycle
      y = mulq(mulq(mulq(st_q.cf3, st_d.frac) + st_q.cf2, st_d.frac) + st_q.cf1, st_d.frac)
          + ext(st_q.p1);
      if (st_q.method == M_LINEAR && modulo_range != '0) begin
        if (y >= md) begin
          y = y - md;
        end else if (y < 0) begin
          y = y + md;
        end
      end
      // Quadratic and cubic pass through unwrapped
      st_d.pos     = POS_W'(y);
      st_d.pos_vld = 1'b1;
    end

    if (sync_edge) begin
      st_d.interval = st_q.tick_cnt;
      st_d.tick_cnt = '0;
      if (st_q.mode == SYNC_PLL) begin
        // Pull the local frame onto the master sync and report the offset
        st_d.phase_err = (st_q.cyc_cnt > (st_q.cycle_ticks >> 1))
                         ? $signed(st_q.cyc_cnt - st_q.cycle_ticks) : $signed(st_q.cyc_cnt);
        st_d.cyc_cnt   = '0;
      end else begin
        // Step rescaled from the measured sync interval
        st_d.div_start = ~div_busy;
      end
    end

    if (div_done) begin
      st_d.step = div_quot;
    end

    if (setpoint_valid) begin
      n0 = ext(setpoint_pos);
      // First demand after reset primes the whole history
      n1 = (st_q.fill == '0) ? n0 : ext(st_q.p0);
      n2 = (st_q.fill == '0) ? n0 : ext(st_q.p1);
      n3 = (st_q.fill == '0) ? n0 : ext(st_q.p2);
      st_d.p0   = setpoint_pos;
      st_d.p1   = POS_W'(n1);
      st_d.p2   = POS_W'(n2);
      st_d.p3   = POS_W'(n3);
      st_d.fill = (st_q.fill == HIST_FULL) ? HIST_FULL : st_q.fill + 1'b1;
      st_d.frac = '0;
      lin_sel = (interpolation_method_select == SEL_LIN_A) ||
                (interpolation_method_select == SEL_LIN_B);
      st_d.fault = lin_sel && (st_q.mode == SYNC_TSTAMP);
      if (lin_sel && st_q.mode == SYNC_PLL) begin
        dl = n0 - n1;
        if (modulo_range != '0) begin
          if (dl > (md >>> 1)) begin
            dl = dl - md;
          end else if (dl < -(md >>> 1)) begin
            dl = dl + md;
          end
        end
        st_d.method = M_LINEAR;
        st_d.cf3    = '0;
        st_d.cf2    = '0;
        st_d.cf1    = dl;
      end else if (interpolation_method_select == SEL_CUBIC) begin
        st_d.method = M_CUBIC;
        st_d.cf3    = (n0 - 3 * n1 + 3 * n2 - n3) / 6;
        st_d.cf2    = (n0 - 2 * n1 + n2) >>> 1;
        st_d.cf1    = n0 - n1 - st_d.cf3 - st_d.cf2;
      end else begin
        st_d.method = M_QUAD;
        st_d.cf3    = '0;
        st_d.cf2    = (n0 - 2 * n1 + n2) >>> 1;
        st_d.cf1    = (n0 - n2) >>> 1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q             <= '0;
      st_q.cycle_ticks <= CYC_W'(1);
      st_q.method      <= M_LINEAR;
    end else begin
      st_q <= st_d;
    end
  end

  assign position_cmd        = st_q.pos;
  assign position_cmd_valid  = st_q.pos_vld;
  assign sync_method_active  = st_q.mode;
  assign method_fault        = st_q.fault;
  assign sync_interval_ticks = st_q.interval;
  assign pll_phase_err       = st_q.phase_err;

  ////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_method_hold: assert property (
    !$past(cycle_time_wr) |-> $stable(sync_method_active))
    else $error("sync method changed without cycle time write");
  chk_linear_fault: assert property (
    setpoint_valid && st_q.mode == SYNC_TSTAMP && interpolation_method_select == SEL_LIN_B
    |=> method_fault && st_q.method == M_QUAD)
    else $error("linear accepted under interval sync");
  chk_linear_fit: assert property (
    setpoint_valid && st_q.mode == SYNC_PLL && interpolation_method_select == SEL_LIN_A
    && modulo_range == '0 |=> st_q.method == M_LINEAR && st_q.cf2 == '0
    && st_q.cf1 == ext(st_q.p0) - ext(st_q.p1))
    else $error("linear coefficients wrong");
  chk_quad_fit: assert property (
    setpoint_valid && interpolation_method_select == SEL_QUAD
    |=> st_q.method == M_QUAD && st_q.cf3 == '0)
    else $error("quadratic fit not selected");
  chk_cubic_hist: assert property (
    setpoint_valid && interpolation_method_select == SEL_CUBIC
    |=> st_q.method == M_CUBIC && st_q.p1 == $past(st_q.p0) && st_q.p3 == $past(st_q.p2))
    else $error("cubic history not shifted");
  chk_mod_range: assert property (
    position_cmd_valid && st_q.method == M_LINEAR && modulo_range != '0
    && $stable(modulo_range) |-> $unsigned(position_cmd) < modulo_range)
    else $error("linear output outside modulo range");
  chk_frac_restart: assert property (
    setpoint_valid |=> st_q.frac == '0)
    else $error("cycle fraction not restarted");
  chk_pll_align: assert property (
    sync_method_active == SYNC_PLL && st_d.sync_f && !st_q.sync_f |=> st_q.cyc_cnt == '0)
    else $error("frame not aligned to sync");
  chk_interval: assert property (
    st_d.sync_f && !st_q.sync_f |=> sync_interval_ticks == $past(st_q.tick_cnt))
    else $error("sync interval not captured");
endmodule : interpolated_position_sync

/* rtl/ips_pkg.sv */
// Purpose: Shared constants and types for the interpolated position setpoint path.
// Assumes: 100 MHz system clock; bus cycle time is given in microseconds.
// Notes:   The control tick is 1 us, so a cycle time in us equals a count of ticks.
package ips_pkg;
  localparam int POS_W         = 32;
  localparam int CW            = 40;
  localparam int FRAC_W        = 16;
  localparam int CYC_W         = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CTRL_TICK_NS  = 1000;
  localparam int TICK_CYC      = (CTRL_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W        = 8;
  // Largest sync jitter the master may show for phase-locked operation
  localparam int JITTER_MAX_NS = 50000;

  localparam logic [2:0] SEL_LIN_A = 3'h0;
  localparam logic [2:0] SEL_LIN_B = 3'h7;
  localparam logic [2:0] SEL_QUAD  = 3'h6;
  localparam logic [2:0] SEL_CUBIC = 3'h5;

  localparam logic       SYNC_PLL    = 1'h0;
  localparam logic       SYNC_TSTAMP = 1'h1;

  localparam logic [FRAC_W:0] FRAC_ONE = 17'h10000;
  localparam logic [1:0]      HIST_FULL = 2'h3;

  typedef enum logic [1:0] {M_LINEAR, M_QUAD, M_CUBIC} method_t;
endpackage : ips_pkg

/* rtl/recip_div.sv */
// Purpose: Serial restoring divider giving the per-tick time step 2^FRAC_W / divisor.
// Assumes: divisor is not zero; a start while busy is ignored.
// Notes:   One quotient bit per clock, result valid with the done pulse.
`timescale 1ns/1ps
module recip_div
  import ips_pkg::*;
#(
  parameter int N_W = CYC_W,
  parameter int Q_W = FRAC_W + 1
) (
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic           start,
  input  wire logic [N_W-1:0] divisor,
  output logic                busy,
  output logic                done,
  output logic [Q_W-1:0]      quot
);
  localparam int CNT_W = $clog2(Q_W + 1);

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [CNT_W-1:0] cnt;
    logic [N_W:0]     rem;
    logic [Q_W-1:0]   quot;
    logic [N_W-1:0]   dvs;
  } div_st_t;

  div_st_t st_q;
  div_st_t st_d;

  always_comb begin
    logic [N_W:0]     trial;
    logic [CNT_W-1:0] idx;
    trial = '0;
    idx   = '0;
    st_d      = st_q;
    st_d.done = 1'b0;
    if (!st_q.busy) begin
      if (start) begin
        st_d.busy = 1'b1;
        st_d.cnt  = CNT_W'(Q_W);
        st_d.rem  = '0;
        st_d.quot = '0;
        st_d.dvs  = (divisor == '0) ? N_W'(1) : divisor;
      end
    end else begin
      idx   = st_q.cnt - 1'b1;
      // The dividend is a single one at bit FRAC_W
      trial = {st_q.rem[N_W-1:0], (idx == CNT_W'(FRAC_W))};
      if (trial >= {1'b0, st_q.dvs}) begin
        st_d.rem  = trial - {1'b0, st_q.dvs};
        st_d.quot = {st_q.quot[Q_W-2:0], 1'b1};
      end else begin
        st_d.rem  = trial;
        st_d.quot = {st_q.quot[Q_W-2:0], 1'b0};
      end
      st_d.cnt = idx;
      if (idx == '0) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = st_q.busy;
  assign done = st_q.done;
  assign quot = st_q.quot;
endmodule : recip_div
